// file: core/clock_supervisor_counter.sv
// clock supervisor counter: counts an external oscillator during a time-base window
// assumes: APB master on ref_clk; window taps, run level and oscillators arrive asynchronously
`default_nettype none
`include "clock_supervisor_regs.svh"

// Behaviour
// - one control bit picks main or sub oscillator as count source
// - three-bit field picks window tap, 2^3 to 2^17 periods in steps of two
// - count external clock only between two rising edges of the window
// - enable waits for next window rise, stops at the second rise
// - enable bit reads as running flag and clears itself when done
// - software clearing enable while running clears count and result
// - result cleared when software sets enable from zero to one
// - result reads zero while enable is one
// - counter saturates at 255 and never wraps
// - lost clock stops counting; result cleared after two window falls
// - eight-bit result is read only and holds the final count
// - reset clears all four registers to zero
// - control bits 7 to 5 read zero and ignore writes
// - enable and counter clear on first window fall after second rise
// - counter stops while the time-base timer is stopped
module clock_supervisor_counter (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire clock_supervisor_pkg::addr_t paddr,
    input wire clock_supervisor_pkg::word_t pwdata,
    output clock_supervisor_pkg::word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] windowTap,
    input wire logic timeBaseRun,
    input wire logic mainOscClk,
    input wire logic subOscClk,
    output logic irq
);
    import clock_supervisor_pkg::*;

    meas_state_t state_r, state_nxt;
    byte_t count_r, count_nxt;
    byte_t result_r, result_nxt;
    logic srcSel_r, srcSel_nxt;
    wsel_t wsel_r, wsel_nxt;
    logic [1:0] lossCnt_r, lossCnt_nxt;
    logic extSeen_r, extSeen_nxt;
    logic [1:0] status_r, status_nxt;
    logic [1:0] mask_r, mask_nxt;
    word_t prdata_r, prdata_nxt;
    logic tbRun_m_r, tbRun_r;
    logic tbRun_m_nxt, tbRun_nxt;
    logic [1:0] settle_r, settle_nxt;
    logic irq_r, irq_nxt;

    logic running;
    logic doneEvt, lossEvt;
    logic setup, access, wrAccess;
    logic hitCtrl, hitResult, hitStatus, hitMask, hit;
    logic winSrc, extSrc;
    word_t rdMux;

    edge_if winEv();
    edge_if extEv();

    assign winSrc = windowTap[wsel_r];
    assign extSrc = srcSel_r ? subOscClk : mainOscClk;

    edge_sync winSync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .asyncIn(winSrc),
        .ev(winEv)
    );

    edge_sync extSync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .asyncIn(extSrc),
        .ev(extEv)
    );

    assign running = (state_r != IDLE);

    // bus decode; the upper two address bits must be zero for a hit
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wrAccess = access & pwrite;
    assign hitCtrl = (paddr[15:14] == 2'h0) && (paddr[13:2] == `CTRL_IDX);
    assign hitResult = (paddr[15:14] == 2'h0) && (paddr[13:2] == `RESULT_IDX);
    assign hitStatus = (paddr[15:14] == 2'h0) && (paddr[13:2] == `IRQ_STATUS_IDX);
    assign hitMask = (paddr[15:14] == 2'h0) && (paddr[13:2] == `IRQ_MASK_IDX);
    assign hit = hitCtrl | hitResult | hitStatus | hitMask;

    always_comb begin
        rdMux = 32'h0000_0000;
        if (hitCtrl) begin
            // bits 7 to 5 are never stored
            rdMux[`SRC_BIT] = srcSel_r;
            rdMux[`WSEL_MSB:`WSEL_LSB] = wsel_r;
            rdMux[`EN_BIT] = running;
        end else if (hitResult) begin
            rdMux[7:0] = running ? 8'h00 : result_r;
        end else if (hitStatus) begin
            rdMux[1:0] = status_r;
        end else if (hitMask) begin
            rdMux[1:0] = mask_r;
        end
    end

    // read data is captured in the setup phase so it comes from a flop
    always_comb begin
        prdata_nxt = prdata_r;
        if (setup) begin
            prdata_nxt = pwrite ? 32'h0000_0000 : rdMux;
        end
    end

    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        result_nxt = result_r;
        srcSel_nxt = srcSel_r;
        wsel_nxt = wsel_r;
        lossCnt_nxt = lossCnt_r;
        extSeen_nxt = extSeen_r;
        settle_nxt = settle_r;
        doneEvt = 1'b0;
        lossEvt = 1'b0;

        case (state_r)
            IDLE: begin
                count_nxt = 8'h00;
                settle_nxt = 2'h0;
            end
            ARM: begin
                // the tap mux may just have switched, so a false edge can still be
                // in the synchroniser; wait until it has flushed
                if (settle_r != 2'h0) begin
                    settle_nxt = settle_r - 2'h1;
                end else if (winEv.rise) begin
                    state_nxt = COUNT;
                end
            end
            COUNT: begin
                // a stopped time-base timer freezes the count
                if (extEv.rise && tbRun_r && (count_r != `COUNT_MAX)) begin
                    count_nxt = count_r + 8'h01;
                end
                if (winEv.rise) begin
                    state_nxt = HOLD;
                end
            end
            HOLD: begin
                if (winEv.fall) begin
                    result_nxt = count_r;
                    count_nxt = 8'h00;
                    state_nxt = IDLE;
                    doneEvt = 1'b1;
                end
            end
            default: begin
                state_nxt = IDLE;
            end
        endcase

        // clock-loss watch: a whole window period, fall to fall, with no external edge counts once
        if (running && (settle_r == 2'h0)) begin
            if (extEv.rise) begin
                extSeen_nxt = 1'b1;
            end
            if (winEv.fall) begin
                extSeen_nxt = extEv.rise;
                if (!extSeen_r && !extEv.rise) begin
                    lossCnt_nxt = lossCnt_r + 2'h1;
                    if (lossCnt_r + 2'h1 == `LOSS_EDGES) begin
                        result_nxt = 8'h00;
                        count_nxt = 8'h00;
                        state_nxt = IDLE;
                        doneEvt = 1'b0;
                        lossEvt = 1'b1;
                    end
                end
            end
        end

        // software write of the control register overrides the sequence above
        if (wrAccess && hitCtrl) begin
            srcSel_nxt = pwdata[`SRC_BIT];
            wsel_nxt = pwdata[`WSEL_MSB:`WSEL_LSB];
            if (!running && pwdata[`EN_BIT]) begin
                result_nxt = 8'h00;
                count_nxt = 8'h00;
                lossCnt_nxt = 2'h0;
                extSeen_nxt = 1'b0;
                settle_nxt = `SETTLE_CYCLES;
                state_nxt = ARM;
            end else if (running && !pwdata[`EN_BIT]) begin
                result_nxt = 8'h00;
                count_nxt = 8'h00;
                state_nxt = IDLE;
                doneEvt = 1'b0;
                lossEvt = 1'b0;
            end
        end
        // writes to the result register are dropped
    end

    // sticky events; a set in the same cycle as its clear wins
    always_comb begin
        status_nxt = status_r;
        mask_nxt = mask_r;
        if (wrAccess && hitStatus) begin
            status_nxt = status_r & ~pwdata[1:0];
        end
        if (wrAccess && hitMask) begin
            mask_nxt = pwdata[1:0];
        end
        if (doneEvt) begin
            status_nxt[`DONE_BIT] = 1'b1;
        end
        if (lossEvt) begin
            status_nxt[`LOSS_BIT] = 1'b1;
        end
    end

    // run level passes two flops before it gates the count
    always_comb begin
        tbRun_m_nxt = timeBaseRun;
        tbRun_nxt = tbRun_m_r;
    end

    // registered from next values, so the level moves at the same edge as the status
    always_comb begin
        irq_nxt = |(status_nxt & mask_nxt);
    end

    // bus group: the read word stands from its setup edge until the next setup
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // measurement group
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= IDLE;
            count_r <= 8'h00;
            result_r <= `RESULT_RESET;
            srcSel_r <= 1'(`CTRL_RESET >> `SRC_BIT);
            wsel_r <= 3'(`CTRL_RESET >> `WSEL_LSB);
            lossCnt_r <= 2'h0;
            extSeen_r <= 1'b0;
            settle_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            result_r <= result_nxt;
            srcSel_r <= srcSel_nxt;
            wsel_r <= wsel_nxt;
            lossCnt_r <= lossCnt_nxt;
            extSeen_r <= extSeen_nxt;
            settle_r <= settle_nxt;
        end
    end

    // event group
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_r <= `IRQ_RESET;
            mask_r <= `IRQ_RESET;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    // time-base run level synchroniser
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tbRun_m_r <= 1'b0;
            tbRun_r <= 1'b0;
        end else begin
            tbRun_m_r <= tbRun_m_nxt;
            tbRun_r <= tbRun_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = access;
    assign pslverr = access & ~hit;
    assign irq = irq_r;
endmodule
`default_nettype wire

// file: core/clock_supervisor_regs.svh
// register map, field positions, reset values and counts of the clock supervisor
// assumes: included by the design files by bare name
`ifndef CLOCK_SUPERVISOR_REGS_SVH
`define CLOCK_SUPERVISOR_REGS_SVH

// register indices; byte address is four times the index
`define CTRL_IDX 12'hFE9
`define RESULT_IDX 12'hFEA
`define IRQ_STATUS_IDX 12'hFEB
`define IRQ_MASK_IDX 12'hFEC

// control register fields
`define EN_BIT 0
`define WSEL_LSB 1
`define WSEL_MSB 3
`define SRC_BIT 4

// interrupt status fields
`define DONE_BIT 0
`define LOSS_BIT 1

// reset values
`define CTRL_RESET 8'h00
`define RESULT_RESET 8'h00
`define IRQ_RESET 2'h0

// counts
`define COUNT_MAX 8'hFF
`define LOSS_EDGES 2'h2
// cycles after an arm write in which window edges are ignored while the window synchroniser flushes
`define SETTLE_CYCLES 2'h3

`endif

// file: core/clock_supervisor_pkg.sv
// types shared by the clock supervisor files
// assumes: compiled before every other design file
`default_nettype none
package clock_supervisor_pkg;
    typedef logic [31:0] word_t;
    typedef logic [15:0] addr_t;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] wsel_t;
    typedef enum {IDLE, ARM, COUNT, HOLD} meas_state_t;
endpackage
`default_nettype wire

// file: core/edge_if.sv
// edge events of one synchronised signal, handed from the synchroniser to the controller
// assumes: one producer and one consumer on ref_clk
`default_nettype none
interface edge_if;
    logic rise;
    logic fall;
    modport drv (output rise, output fall);
    modport use_ (input rise, input fall);
endinterface
`default_nettype wire

// file: core/edge_sync.sv
// two-flop synchroniser with edge detection behind it
// assumes: asyncIn toggles slower than half the ref_clk rate
`default_nettype none
module edge_sync (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic asyncIn,
    edge_if.drv ev
);
    logic meta_r, meta_nxt;
    logic stable_r, stable_nxt;
    logic last_r, last_nxt;

    always_comb begin
        meta_nxt = asyncIn;
        stable_nxt = meta_r;
        last_nxt = stable_r;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            stable_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            stable_r <= stable_nxt;
            last_r <= last_nxt;
        end
    end

    // edges are taken only behind the second flop
    assign ev.rise = stable_r & ~last_r;
    assign ev.fall = ~stable_r & last_r;
endmodule
`default_nettype wire

// file: verification/osc_model.sv
// external main and sub oscillators seen by the supervisor
// assumes: a stopped oscillator parks its output low
`default_nettype none
module osc_model (
    input wire logic mainOn,
    input wire logic subOn,
    output logic mainOscClk,
    output logic subOscClk
);
    timeunit 1ns;
    timeprecision 100ps;
    initial mainOscClk = 1'b0;
    initial subOscClk = 1'b0;
    always #20 mainOscClk = mainOn ? ~mainOscClk : 1'b0;
    always #50 subOscClk = subOn ? ~subOscClk : 1'b0;
endmodule
`default_nettype wire

// file: verification/clock_supervisor_counter_checker.sv
// port assertions for the clock supervisor, bound into the design
// assumes: one ref_clk domain, synchronous active-high reset
`default_nettype none
`include "clock_supervisor_regs.svh"
module clock_supervisor_counter_checker (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire clock_supervisor_pkg::addr_t paddr,
    input wire clock_supervisor_pkg::word_t pwdata,
    input wire clock_supervisor_pkg::word_t prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] windowTap,
    input wire logic timeBaseRun,
    input wire logic mainOscClk,
    input wire logic subOscClk,
    input wire logic irq
);
    import clock_supervisor_pkg::*;
    wire logic acc = psel && penable;
    wire logic setup = psel && !penable;
    wire logic isCtrl = paddr[15:2] == {2'h0, `CTRL_IDX};
    wire logic isRes = paddr[15:2] == {2'h0, `RESULT_IDX};
    wire logic isMask = paddr[15:2] == {2'h0, `IRQ_MASK_IDX};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    ready_follow_a: assert property (pready == acc) else $error("pready mismatch");
    reset_clear_a: assert property ($fell(sys_rst) |-> !irq && prdata == 32'h0)
        else $error("not clear after reset");
    ctrl_reserved_a: assert property (acc && !pwrite && isCtrl |-> prdata[31:5] == 27'h0)
        else $error("reserved control bits set");
    result_width_a: assert property (acc && !pwrite && isRes |-> prdata[31:8] == 24'h0)
        else $error("result wider than a byte");
    arm_clears_a: assert property (acc && pwrite && isCtrl && pwdata[`EN_BIT] ##1
        setup && !pwrite && isRes |=> prdata == 32'h0) else $error("result not zero on arm");
    cancel_stops_a: assert property (acc && pwrite && isCtrl && !pwdata[`EN_BIT] ##1
        setup && !pwrite && isCtrl |=> !prdata[`EN_BIT]) else $error("enable still set");
    select_keep_a: assert property (acc && pwrite && isCtrl ##1 setup && !pwrite && isCtrl
        |=> prdata[4:1] == $past(pwdata[4:1], 2)) else $error("select not kept");
    mask_off_a: assert property (acc && pwrite && isMask && pwdata[1:0] == 2'h0 |=> !irq)
        else $error("irq with mask clear");
    cover property (acc && pwrite && isCtrl && pwdata[`EN_BIT]);
    cover property ($rose(irq));
    cover property (acc && !pwrite && isRes && prdata[7:0] == 8'hFF);
endmodule
bind clock_supervisor_counter clock_supervisor_counter_checker chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .windowTap(windowTap), .timeBaseRun(timeBaseRun), .mainOscClk(mainOscClk),
    .subOscClk(subOscClk));
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the clock supervisor counter
// assumes: window taps are scaled down, tap n has a period of 2^(n+4) cycles
`default_nettype none
`include "clock_supervisor_regs.svh"
module tb import clock_supervisor_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [13:0] CTRL = {2'h0, `CTRL_IDX}, RES = {2'h0, `RESULT_IDX};
    localparam logic [13:0] STAT = {2'h0, `IRQ_STATUS_IDX}, MASK = {2'h0, `IRQ_MASK_IDX};
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, timeBaseRun = 1;
    logic mainOn = 1, subOn = 1, pready, pslverr, irq, mainOscClk, subOscClk, slvErr;
    addr_t paddr = '0;
    word_t pwdata = '0, prdata, rd;
    logic [7:0] windowTap;
    logic [15:0] tbc = '0;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) tbc <= tbc + 16'h1;
    // shortest window is 16 cycles, well over two bus clocks
    always_comb for (int i = 0; i < 8; i++) windowTap[i] = tbc[i + 3];
    clock_supervisor_counter dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .windowTap(windowTap), .timeBaseRun(timeBaseRun),
        .mainOscClk(mainOscClk), .subOscClk(subOscClk), .irq(irq));
    osc_model osc (.mainOn(mainOn), .subOn(subOn), .mainOscClk(mainOscClk),
        .subOscClk(subOscClk));
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input word_t got, input word_t lo, input word_t hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // leaves the bus selected so a following call makes a back-to-back transfer
    task automatic xfer(input logic w, input logic [13:0] ix, input word_t d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        slvErr = pslverr;
    endtask
    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rdchk(input logic [13:0] ix, input word_t lo, input word_t hi);
        xfer(1'b0, ix, 32'h0);
        chk(rd, lo, hi);
    endtask
    task automatic waitIdle();
        do begin
            xfer(1'b0, CTRL, 32'h0);
            idle();
        end while (rd[`EN_BIT] !== 1'b0);
    endtask
    function automatic int expCount(logic s, int c);
        int e;
        e = (2 ** (c + 4)) * 5 / (s ? 100 : 40);
        return e > 255 ? 255 : e;
    endfunction
    initial begin
        int e;
        logic s;
        word_t v;
        void'($urandom(32'h2FFB));
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdchk(CTRL, 0, 0);
        rdchk(RES, 0, 0);
        v = $urandom() & 32'hFFFF_FFFE;
        xfer(1'b1, CTRL, v);
        rdchk(CTRL, v & 32'h1E, v & 32'h1E);
        xfer(1'b1, RES, 32'hFF);
        rdchk(RES, 0, 0);
        chk(slvErr, 0, 0);
        rdchk(14'h1000 | 14'($urandom() & 32'hFFF), 0, 0);
        chk(slvErr, 1, 1);
        xfer(1'b1, MASK, 32'h1);
        idle();
        for (int c = 0; c < 8; c++) begin
            // the sub clock is slower than the shortest window and would trip the loss watch
            s = (c == 7 || c == 0) ? 1'b0 : (c == 1) ? 1'b1 : 1'($urandom());
            xfer(1'b1, CTRL, {27'h0, s, 3'(c), 1'b1});
            rdchk(RES, 0, 0);
            idle();
            waitIdle();
            e = expCount(s, c);
            rdchk(RES, e > 0 ? e - 1 : 0, e == 255 ? 255 : e + 1);
            rdchk(STAT, 1, 1);
            chk(irq, 1, 1);
            xfer(1'b1, STAT, 32'h1);
            idle();
            chk(irq, 0, 0);
        end
        xfer(1'b1, CTRL, 32'hF);
        idle();
        repeat ($urandom_range(400, 50)) @(posedge ref_clk);
        xfer(1'b1, CTRL, 32'hE);
        rdchk(CTRL, 32'hE, 32'hE);
        rdchk(RES, 0, 0);
        rdchk(STAT, 0, 0);
        xfer(1'b1, MASK, 32'h0);
        idle();
        mainOn <= 1'b0;
        xfer(1'b1, CTRL, 32'h5);
        idle();
        waitIdle();
        rdchk(RES, 0, 0);
        rdchk(STAT, 2, 2);
        chk(irq, 0, 0);
        xfer(1'b1, STAT, 32'h3);
        idle();
        mainOn <= 1'b1;
        timeBaseRun <= 1'b0;
        xfer(1'b1, CTRL, 32'h7);
        idle();
        waitIdle();
        rdchk(RES, 0, 0);
        idle();
        summarize();
    end
endmodule
`default_nettype wire
